/* hw/tql_defs.vh */
// Purpose: Shared constants of the torque and quadrant limit block
// Assumes: 25 MHz clock, 32-bit register bus
// Notes:   Offsets are byte addresses
`ifndef TQL_DEFS_VH
`define TQL_DEFS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TQL_OFS_CTRL    8'h00
`define TQL_OFS_DELAY   8'h04
`define TQL_OFS_THR1    8'h08
`define TQL_OFS_THR2    8'h0c
`define TQL_OFS_SLOPE1  8'h10
`define TQL_OFS_SLOPE2  8'h14
`define TQL_OFS_ILIM    8'h18
`define TQL_OFS_ILIM2   8'h1c
`define TQL_OFS_SPDDEM  8'h20
`define TQL_OFS_STATUS  8'h24
`define TQL_OFS_OVRLIM  8'h28
`define TQL_OFS_SPDREF  8'h2c

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define TQL_CTRL_MODE0  0
`define TQL_CTRL_MODE1  1
`define TQL_CTRL_Q2EN   2
`define TQL_CTRL_Q3EN   3
`define TQL_CTRL_Q4EN   4
`define TQL_CTRL_AUTOEN 5
`define TQL_CTRL_LIM2   6

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TQL_RST_DELAY   8'h00
`define TQL_RST_THR     10'h3e8
`define TQL_RST_SLOPE   8'h00
`define TQL_RST_ILIM    10'h3e8
`define TQL_RST_SPDDEM  11'h000

// ----------------------------------------
// Timing
// ----------------------------------------
`define TQL_CLK_HZ      25000000
`define TQL_TICK_S      1
// One second of clock at 25 MHz, sized to the timer's tick counter
`define TQL_SEC_CYCLES  25'd25000000
`define TQL_SLOPE_SHIFT 7

`endif

/* hw/tql_sec_timer.v */
// Purpose: Whole-second interval timer started by the run command
// Assumes: run_in already synchronised
// Notes:   Fires once per run
`timescale 1ns/1ps
`include "tql_defs.vh"

module tql_sec_timer #(
   parameter [24:0] SEC_CYCLES = `TQL_SEC_CYCLES
)(
   input  wire       clock_in,
   input  wire       rst_b_in,
   input  wire       run_in,
   input  wire       enable_in,
   input  wire [7:0] delay_in,
   output reg        fire_out
);

   reg [24:0] tick_q;
   reg [7:0]  sec_q;
   reg        run_q;
   reg        done_q;

   always @(posedge clock_in)
   begin
      fire_out <= 1'b0;
      run_q    <= run_in;
      if (!rst_b_in)
      begin
         tick_q <= 25'h0000000;
         sec_q  <= 8'h00;
         run_q  <= 1'b0;
         done_q <= 1'b0;
      end
      else if (!run_in || !run_q)
      begin
         // Stopped, or first cycle of a new run: restart
         tick_q <= 25'h0000000;
         sec_q  <= 8'h00;
         done_q <= 1'b0;
      end
      else if (!done_q)
      begin
         if (sec_q == delay_in)
         begin
            fire_out <= enable_in;
            done_q   <= 1'b1;
         end
         else if (tick_q == SEC_CYCLES - 25'h0000001)
         begin
            tick_q <= 25'h0000000;
            sec_q  <= sec_q + 8'h01;
         end
         else
            tick_q <= tick_q + 25'h0000001;
      end
   end

endmodule // tql_sec_timer

/* hw/tql_taper.v */
// Purpose: One speed-dependent current taper stage
// Assumes: Unsigned speed magnitude and limits, 0 to 1000
// Notes:   Combinational; result never drops below zero
`timescale 1ns/1ps
`include "tql_defs.vh"

module tql_taper (
   input  wire [9:0] base_in,
   input  wire [9:0] speed_in,
   input  wire [9:0] thresh_in,
   input  wire [7:0] slope_in,
   output reg  [9:0] limit_out,
   output reg        exceeded_out
);

   reg [9:0]  over;
   reg [17:0] prod;
   reg [10:0] drop;

   always @*
   begin
      exceeded_out = (speed_in > thresh_in);
      over         = exceeded_out ? (speed_in - thresh_in) : 10'h000;
      // Slope is current change per speed change, times 128
      prod         = slope_in * over;
      drop         = prod[17:`TQL_SLOPE_SHIFT];
      if (drop >= {1'b0, base_in})
         limit_out = 10'h000;
      else
         limit_out = base_in - drop[9:0];
   end

endmodule // tql_taper

/* hw/tql_limit_top.v */
// Purpose: Torque mode, quadrant enables, auto limit change, tapers
// Assumes: Speed, torque and demand words come from this clock domain
// Notes:   AHB-Lite slave, reads take one wait state
`timescale 1ns/1ps
`include "tql_defs.vh"

module tql_limit_top #(
   parameter [24:0] SEC_CYCLES = `TQL_SEC_CYCLES
)(
   input  wire               clock_in,
   input  wire               rst_b_in,
   input  wire               four_quadrant_variant_in,
   input  wire               run_in,
   input  wire signed [10:0] speed_fb_in,
   input  wire signed [10:0] torque_dem_in,
   input  wire               hsel_in,
   input  wire [7:0]         haddr_in,
   input  wire [1:0]         htrans_in,
   input  wire               hwrite_in,
   input  wire [2:0]         hsize_in,
   input  wire [31:0]        hwdata_in,
   input  wire               hready_in,
   output reg  [31:0]        hrdata_out,
   output reg                hreadyout_out,
   output reg                hresp_out,
   output reg  signed [10:0] speed_ref_out,
   output reg  signed [10:0] current_dem_out,
   output reg  [9:0]         ovr_limit_out,
   output reg  [1:0]         quadrant_out,
   output reg                quadrant_ok_out,
   output reg                thr1_exceeded_out,
   output reg                thr2_exceeded_out,
   output reg                limit2_sel_out,
   output reg                coiler_mode_out
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function [9:0] mag11;
      input signed [10:0] v;
      reg [10:0] t;
      begin
         t     = v[10] ? (11'h000 - v) : v;
         mag11 = (t > 11'h3e8) ? 10'h3e8 : t[9:0];
      end
   endfunction

   function signed [10:0] clamp11;
      input signed [10:0] v;
      input [9:0]         lim;
      reg signed [10:0] hi;
      begin
         hi = {1'b0, lim};
         if (v > hi)
            clamp11 = hi;
         else if (v < -hi)
            clamp11 = -hi;
         else
            clamp11 = v;
      end
   endfunction

   // ----------------------------------------
   // Run pin synchroniser
   // ----------------------------------------
   reg run_meta_q;
   reg run_sync_q;

   always @(posedge clock_in)
   begin
      if (!rst_b_in)
      begin
         run_meta_q <= 1'b0;
         run_sync_q <= 1'b0;
      end
      else
      begin
         run_meta_q <= run_in;
         run_sync_q <= run_meta_q;
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   reg [1:0]         mode_q;
   reg               q2_en_q;
   reg               q3_en_q;
   reg               q4_en_q;
   reg               auto_en_q;
   reg               lim2_sel_q;
   reg [7:0]         delay_q;
   reg [9:0]         thr1_q;
   reg [9:0]         thr2_q;
   reg [7:0]         slope1_q;
   reg [7:0]         slope2_q;
   reg [9:0]         ilim_q;
   reg [9:0]         ilim2_q;
   reg signed [10:0] spd_dem_q;

   // Bus pipeline
   reg               wr_pend_q;
   reg               rd_pend_q;
   reg [7:0]         addr_q;

   wire              auto_fire;
   wire [9:0]        taper1_lim;
   wire [9:0]        taper2_lim;
   wire              taper1_exc;
   wire              taper2_exc;

   wire addr_phase = hsel_in & htrans_in[1] & hready_in;
   wire hit_write  = wr_pend_q;

   // ----------------------------------------
   // Bus slave
   // ----------------------------------------
   // Reads stall one cycle so a write just before is always visible
   always @(posedge clock_in)
   begin
      if (!rst_b_in)
      begin
         wr_pend_q     <= 1'b0;
         rd_pend_q     <= 1'b0;
         addr_q        <= 8'h00;
         hreadyout_out <= 1'b1;
         hresp_out     <= 1'b0;
         hrdata_out    <= 32'h00000000;
      end
      else
      begin
         hresp_out <= 1'b0;
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         if (rd_pend_q)
         begin
            hrdata_out    <= read_mux(addr_q);
            hreadyout_out <= 1'b1;
         end
         else if (addr_phase)
         begin
            addr_q        <= haddr_in;
            wr_pend_q     <= hwrite_in;
            rd_pend_q     <= ~hwrite_in;
            hreadyout_out <= hwrite_in;
         end
      end
   end

   function [31:0] read_mux;
      input [7:0] a;
      begin
         case (a)
            `TQL_OFS_CTRL:   read_mux = {25'h0, lim2_sel_q, auto_en_q, q4_en_q,
                                         q3_en_q, q2_en_q, mode_q};
            `TQL_OFS_DELAY:  read_mux = {24'h0, delay_q};
            `TQL_OFS_THR1:   read_mux = {22'h0, thr1_q};
            `TQL_OFS_THR2:   read_mux = {22'h0, thr2_q};
            `TQL_OFS_SLOPE1: read_mux = {24'h0, slope1_q};
            `TQL_OFS_SLOPE2: read_mux = {24'h0, slope2_q};
            `TQL_OFS_ILIM:   read_mux = {22'h0, ilim_q};
            `TQL_OFS_ILIM2:  read_mux = {22'h0, ilim2_q};
            `TQL_OFS_SPDDEM: read_mux = {{21{spd_dem_q[10]}}, spd_dem_q};
            `TQL_OFS_STATUS: read_mux = {25'h0, run_sync_q, quadrant_ok_out,
                                         quadrant_out, thr2_exceeded_out,
                                         thr1_exceeded_out, coiler_mode_out};
            `TQL_OFS_OVRLIM: read_mux = {22'h0, ovr_limit_out};
            `TQL_OFS_SPDREF: read_mux = {{21{speed_ref_out[10]}}, speed_ref_out};
            default:         read_mux = 32'h00000000;
         endcase
      end
   endfunction

   // ----------------------------------------
   // Register file
   // ----------------------------------------
   always @(posedge clock_in)
   begin
      if (!rst_b_in)
      begin
         mode_q    <= 2'b00;
         q2_en_q   <= four_quadrant_variant_in;
         q3_en_q   <= four_quadrant_variant_in;
         q4_en_q   <= four_quadrant_variant_in;
         auto_en_q <= 1'b0;
         lim2_sel_q <= 1'b0;
         delay_q   <= `TQL_RST_DELAY;
         thr1_q    <= `TQL_RST_THR;
         thr2_q    <= `TQL_RST_THR;
         slope1_q  <= `TQL_RST_SLOPE;
         slope2_q  <= `TQL_RST_SLOPE;
         ilim_q    <= `TQL_RST_ILIM;
         ilim2_q   <= `TQL_RST_ILIM;
         spd_dem_q <= `TQL_RST_SPDDEM;
      end
      else
      begin
         if (hit_write)
         begin
            case (addr_q)
               `TQL_OFS_CTRL:
               begin
                  mode_q     <= hwdata_in[`TQL_CTRL_MODE1:`TQL_CTRL_MODE0];
                  q2_en_q    <= hwdata_in[`TQL_CTRL_Q2EN];
                  q3_en_q    <= hwdata_in[`TQL_CTRL_Q3EN];
                  q4_en_q    <= hwdata_in[`TQL_CTRL_Q4EN];
                  auto_en_q  <= hwdata_in[`TQL_CTRL_AUTOEN];
                  lim2_sel_q <= hwdata_in[`TQL_CTRL_LIM2];
               end
               `TQL_OFS_DELAY:  delay_q   <= hwdata_in[7:0];
               `TQL_OFS_THR1:   thr1_q    <= sat1000(hwdata_in[9:0]);
               `TQL_OFS_THR2:   thr2_q    <= sat1000(hwdata_in[9:0]);
               `TQL_OFS_SLOPE1: slope1_q  <= hwdata_in[7:0];
               `TQL_OFS_SLOPE2: slope2_q  <= hwdata_in[7:0];
               `TQL_OFS_ILIM:   ilim_q    <= sat1000(hwdata_in[9:0]);
               `TQL_OFS_ILIM2:  ilim2_q   <= sat1000(hwdata_in[9:0]);
               `TQL_OFS_SPDDEM: spd_dem_q <= hwdata_in[10:0];
               default:         ;
            endcase
         end
         // Timer event beats a software clear in the same cycle
         if (auto_fire)
            lim2_sel_q <= 1'b1;
      end
   end

   function [9:0] sat1000;
      input [9:0] v;
      begin
         sat1000 = (v > 10'h3e8) ? 10'h3e8 : v;
      end
   endfunction

   // ----------------------------------------
   // Auto limit change timer
   // ----------------------------------------
   tql_sec_timer #(
      .SEC_CYCLES (SEC_CYCLES)
   ) u_timer (
      .clock_in  (clock_in),
      .rst_b_in  (rst_b_in),
      .run_in    (run_sync_q),
      .enable_in (auto_en_q),
      .delay_in  (delay_q),
      .fire_out  (auto_fire)
   );

   // ----------------------------------------
   // Current tapers
   // ----------------------------------------
   wire [9:0] spd_mag = mag11(speed_fb_in);

   // Taper two works on what taper one leaves
   tql_taper u_taper1 (
      .base_in      (ilim_q),
      .speed_in     (spd_mag),
      .thresh_in    (thr1_q),
      .slope_in     (slope1_q),
      .limit_out    (taper1_lim),
      .exceeded_out (taper1_exc)
   );

   tql_taper u_taper2 (
      .base_in      (taper1_lim),
      .speed_in     (spd_mag),
      .thresh_in    (thr2_q),
      .slope_in     (slope2_q),
      .limit_out    (taper2_lim),
      .exceeded_out (taper2_exc)
   );

   // ----------------------------------------
   // Mode, quadrant and limit datapath
   // ----------------------------------------
   reg               coiler_d;
   reg [1:0]         quad_d;
   reg               quad_ok_d;
   reg signed [10:0] spd_ref_d;
   reg [9:0]         ovr_lim_d;
   reg signed [10:0] cur_dem_d;

   always @*
   begin
      coiler_d = (mode_q == 2'b11);
      // Zero counts as positive for both signs
      case ({speed_fb_in[10], torque_dem_in[10]})
         2'b00:   begin quad_d = 2'd0; quad_ok_d = 1'b1;    end
         2'b10:   begin quad_d = 2'd1; quad_ok_d = q2_en_q; end
         2'b11:   begin quad_d = 2'd2; quad_ok_d = q3_en_q; end
         2'b01:   begin quad_d = 2'd3; quad_ok_d = q4_en_q; end
         default: begin quad_d = 2'd0; quad_ok_d = 1'b0;    end
      endcase
      if (coiler_d && (speed_fb_in[10] != torque_dem_in[10]))
         spd_ref_d = 11'sh000;
      else
         spd_ref_d = spd_dem_q;
      if (lim2_sel_q && (ilim2_q < taper2_lim))
         ovr_lim_d = ilim2_q;
      else
         ovr_lim_d = taper2_lim;
      if (quad_ok_d)
         cur_dem_d = clamp11(torque_dem_in, ovr_lim_d);
      else
         cur_dem_d = 11'sh000;
   end

   always @(posedge clock_in)
   begin
      if (!rst_b_in)
      begin
         speed_ref_out     <= 11'sh000;
         current_dem_out   <= 11'sh000;
         ovr_limit_out     <= 10'h000;
         quadrant_out      <= 2'd0;
         quadrant_ok_out   <= 1'b0;
         thr1_exceeded_out <= 1'b0;
         thr2_exceeded_out <= 1'b0;
         limit2_sel_out    <= 1'b0;
         coiler_mode_out   <= 1'b0;
      end
      else
      begin
         speed_ref_out     <= spd_ref_d;
         current_dem_out   <= cur_dem_d;
         ovr_limit_out     <= ovr_lim_d;
         quadrant_out      <= quad_d;
         quadrant_ok_out   <= quad_ok_d;
         thr1_exceeded_out <= taper1_exc;
         thr2_exceeded_out <= taper2_exc;
         limit2_sel_out    <= lim2_sel_q;
         coiler_mode_out   <= coiler_d;
      end
   end

endmodule // tql_limit_top

/* test/tql_limit_props.sv */
// Purpose: Port-level assertions for the torque and quadrant limit block
// Assumes: One clock, synchronous active-low reset, single bus slave
// Notes:   Bound to every tql_limit_top instance
`timescale 1ns/1ps

module tql_limit_props (
   input wire               clock_in,
   input wire               rst_b_in,
   input wire signed [10:0] speed_fb_in,
   input wire signed [10:0] torque_dem_in,
   input wire               hsel_in,
   input wire [7:0]         haddr_in,
   input wire [1:0]         htrans_in,
   input wire               hwrite_in,
   input wire               hready_in,
   input wire               hreadyout_out,
   input wire               hresp_out,
   input wire signed [10:0] speed_ref_out,
   input wire signed [10:0] current_dem_out,
   input wire [9:0]         ovr_limit_out,
   input wire [1:0]         quadrant_out,
   input wire               quadrant_ok_out,
   input wire               limit2_sel_out,
   input wire               coiler_mode_out
);
   wire take = hsel_in && htrans_in[1] && hready_in;
   wire ctl_wr = take && hwrite_in && (haddr_in == 8'h00);

   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!rst_b_in);

   // Outputs lag inputs by one edge, so compare against the past inputs
   quad_map_a: assert property ($past(rst_b_in) |-> quadrant_out ==
      {$past(torque_dem_in[10]), $past(speed_fb_in[10] ^ torque_dem_in[10])})
      else $error("quadrant code wrong");
   q1_allowed_a: assert property ($past(rst_b_in) && quadrant_out == 2'h0
      |-> quadrant_ok_out) else $error("quadrant one refused");
   blocked_dem_a: assert property (!quadrant_ok_out |-> current_dem_out == 11'sd0)
      else $error("demand passed in refused quadrant");
   coil_zero_a: assert property (coiler_mode_out && $past(coiler_mode_out)
      && $past(rst_b_in) && ($past(speed_fb_in[10]) != $past(torque_dem_in[10]))
      |-> speed_ref_out == 11'sd0) else $error("coiler reference not zero");
   ovr_max_a: assert property (ovr_limit_out <= 10'h3e8)
      else $error("overriding limit above full scale");
   lim2_hold_a: assert property ($fell(limit2_sel_out) |->
      $past(ctl_wr, 2) || $past(ctl_wr, 3) || $past(ctl_wr, 4))
      else $error("selector cleared without a write");
   read_wait_a: assert property (take && !hwrite_in |=> !hreadyout_out ##1 hreadyout_out)
      else $error("read wait state wrong");
   write_fast_a: assert property (take && hwrite_in |=> hreadyout_out)
      else $error("write stalled");
   okay_resp_a: assert property (hresp_out == 1'b0)
      else $error("error response seen");

   coil_c: cover property (coiler_mode_out && speed_ref_out == 11'sd0);
   lim2_c: cover property ($rose(limit2_sel_out));
   block_c: cover property (!quadrant_ok_out && $past(rst_b_in));
endmodule // tql_limit_props

bind tql_limit_top tql_limit_props u_props (
   .clock_in(clock_in), .rst_b_in(rst_b_in), .speed_fb_in(speed_fb_in),
   .torque_dem_in(torque_dem_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
   .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hready_in(hready_in),
   .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .speed_ref_out(speed_ref_out),
   .current_dem_out(current_dem_out), .ovr_limit_out(ovr_limit_out),
   .quadrant_out(quadrant_out), .quadrant_ok_out(quadrant_ok_out),
   .limit2_sel_out(limit2_sel_out), .coiler_mode_out(coiler_mode_out));

/* test/tb.sv */
// Purpose: Self-checking bench for the torque and quadrant limit block
// Assumes: Short second (10 cycles) so the auto change is reachable
// Notes:   Bus tasks act as the only AHB-Lite master
`timescale 1ns/1ps
`include "tql_defs.vh"

module tb;
   localparam int SEC = 10;
   logic               clk = 0;
   logic               rst_b = 0;
   logic               strap = 0;
   logic               run = 0;
   logic               hsel = 0;
   logic               hwr = 0;
   logic signed [10:0] spd = 0;
   logic signed [10:0] trq = 0;
   logic [7:0]         haddr = 0;
   logic [1:0]         htrans = 0;
   logic [31:0]        hwdata = 0;
   logic [31:0]        rd;
   wire [31:0]         hrdata;
   wire                hrdy, q_ok, l2, coil;
   wire signed [10:0]  sref, cdem;
   wire [9:0]          ovr;
   wire [1:0]          quad;
   wire                t1, t2;
   int                 mismatches = 0;
   int                 samples_checked = 0;
   int                 cyc = 0;

   tql_limit_top #(.SEC_CYCLES(SEC)) dut (
      .clock_in(clk), .rst_b_in(rst_b), .four_quadrant_variant_in(strap), .run_in(run),
      .speed_fb_in(spd), .torque_dem_in(trq), .hsel_in(hsel), .haddr_in(haddr),
      .htrans_in(htrans), .hwrite_in(hwr), .hsize_in(3'h2), .hwdata_in(hwdata),
      .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(),
      .speed_ref_out(sref), .current_dem_out(cdem), .ovr_limit_out(ovr),
      .quadrant_out(quad), .quadrant_ok_out(q_ok), .thr1_exceeded_out(t1),
      .thr2_exceeded_out(t2), .limit2_sel_out(l2), .coiler_mode_out(coil));

   always #20 clk = ~clk;

   // Whole run needs under 2000 cycles
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         mismatches++;
         test_done;
      end
   end

   // ------
   // Tasks
   // ------
   task test_done;
      if (mismatches == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwr <= w;
      do @(posedge clk); while (hrdy !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hrdy !== 1'b1);
      rd = hrdata;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task rdc(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rd, e);
   endtask

   // Extra edges let the new speed and torque reach the registered outputs
   task drv(input logic signed [10:0] s, input logic signed [10:0] t);
      @(posedge clk);
      spd <= s;
      trq <= t;
      repeat (3) @(posedge clk);
      #1;
   endtask

   task runw(input int n, input logic e);
      repeat (n) @(posedge clk);
      #1;
      chk(l2, e);
   endtask

   // ------
   // Tests
   // ------
   initial
   begin
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      rdc(`TQL_OFS_CTRL, 32'h0);
      rdc(`TQL_OFS_DELAY, 32'h0);
      rdc(`TQL_OFS_THR1, 32'h3e8);
      rdc(`TQL_OFS_THR2, 32'h3e8);
      wr(8'h3c, 32'hffff_ffff);
      rdc(8'h3c, 32'h0);
      for (int e = 0; e < 2; e++)
      begin
         wr(`TQL_OFS_CTRL, e ? 32'h1c : 32'h0);
         for (int q = 0; q < 4; q++)
         begin
            drv((q == 1 || q == 2) ? -11'sd300 : 11'sd300, q > 1 ? -11'sd100 : 11'sd100);
            chk(quad, q);
            chk(q_ok, q == 0 || e);
            chk(cdem, (q == 0 || e) ? trq : 11'sd0);
         end
      end
      wr(`TQL_OFS_CTRL, 32'h1f);
      // Demand kept above feedback, as a coiler offset would leave it
      wr(`TQL_OFS_SPDDEM, 32'd600);
      drv(11'sd500, -11'sd100);
      chk(sref, 11'sd0);
      chk(coil, 1'b1);
      drv(11'sd500, 11'sd100);
      chk(sref, 11'sd600);
      rdc(`TQL_OFS_SPDREF, 32'd600);
      drv(-11'sd500, 11'sd100);
      chk(sref, 11'sd0);
      // Uncoiler at standstill: small negative demand must pass through
      wr(`TQL_OFS_SPDDEM, 32'h7fb);
      drv(11'sd0, 11'sd100);
      chk(sref, -11'sd5);
      drv(11'sd0, -11'sd100);
      chk(sref, 11'sd0);
      wr(`TQL_OFS_CTRL, 32'h1d);
      drv(-11'sd500, 11'sd100);
      chk(coil, 1'b0);
      wr(`TQL_OFS_THR1, 32'd200);
      wr(`TQL_OFS_THR2, 32'd400);
      wr(`TQL_OFS_SLOPE1, 32'd128);
      wr(`TQL_OFS_SLOPE2, 32'd64);
      drv(11'sd200, 11'sd100);
      chk(t1, 1'b0);
      chk(ovr, 10'd1000);
      drv(11'sd300, 11'sd100);
      chk(t1, 1'b1);
      chk(t2, 1'b0);
      chk(ovr, 10'd900);
      drv(-11'sd500, -11'sd100);
      chk(t2, 1'b1);
      chk(ovr, 10'd650);
      rdc(`TQL_OFS_STATUS, 32'h36);
      rdc(`TQL_OFS_OVRLIM, 32'd650);
      wr(`TQL_OFS_ILIM2, 32'd500);
      wr(`TQL_OFS_CTRL, 32'h5c);
      drv(-11'sd500, -11'sd800);
      chk(ovr, 10'd500);
      chk(cdem, -11'sd500);
      wr(`TQL_OFS_CTRL, 32'h1c);
      drv(-11'sd500, -11'sd100);
      chk(ovr, 10'd650);
      wr(`TQL_OFS_DELAY, 32'd3);
      wr(`TQL_OFS_CTRL, 32'h3c);
      @(posedge clk);
      run <= 1'b1;
      runw(25, 1'b0);
      runw(15, 1'b1);
      @(posedge clk);
      run <= 1'b0;
      wr(`TQL_OFS_CTRL, 32'h3c);
      runw(50, 1'b0);
      @(posedge clk);
      run <= 1'b1;
      runw(25, 1'b0);
      runw(15, 1'b1);
      @(posedge clk);
      run <= 1'b0;
      wr(`TQL_OFS_CTRL, 32'h1c);
      @(posedge clk);
      run <= 1'b1;
      runw(50, 1'b0);
      @(posedge clk);
      rst_b <= 1'b0;
      strap <= 1'b1;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      rdc(`TQL_OFS_CTRL, 32'h1c);
      test_done;
   end
endmodule // tb
